// ---- include/rbtl_defs.vh ----
// Purpose: Shared constants for the redundant block transfer link.
// Assumes: 100 MHz system clock.
// Notes: Included by the link design file only; word_skid does not include it.
`ifndef RBTL_DEFS_VH
`define RBTL_DEFS_VH
`define CLK_MHZ 100
`define SWITCH_MS 50
`define PRI_READ_WORDS 7'h02
`define BLOCK_MAX_WORDS 7'h40
`define SEQ_ONE 8'h01
`define SEQ_ZERO 8'h00
`define LEN_AUTO 7'h00
`define ST_FAST_BIT 11
`define ST_PRIMARY_BIT 0
`define ST_VALID_BIT 1
`define ST_SWITCH_BIT 2
`define ROLE_ARB 2'h0
`define ROLE_PRI 2'h1
`define ROLE_SEC 2'h2
`define ROLE_FAULT 2'h3
`endif

// ---- logic/word_skid.v ----
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Ready upstream depends only on stored occupancy.
module word_skid #(
    parameter W = 16
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_valid,
    output wire o_ready,
    input wire [W-1:0] i_data,
    output wire o_valid,
    input wire i_ready,
    output wire [W-1:0] o_data
);
    reg [W-1:0] mem_q [0:1];
    reg rd_q;
    reg wr_q;
    reg [1:0] cnt_q;
    wire push = i_valid && (cnt_q != 2'h2);
    wire pop = i_ready && (cnt_q != 2'h0);
    assign o_ready = (cnt_q != 2'h2);
    assign o_valid = (cnt_q != 2'h0);
    assign o_data = mem_q[rd_q];
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= {W{1'b0}};
            mem_q[1] <= {W{1'b0}};
        end else begin
            if (push) begin
                mem_q[wr_q] <= i_data;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule // word_skid

// ---- logic/redundant_block_transfer_link.v ----
// Purpose: Block transfer engine and switchover control of one redundant module.
// Assumes: Link words arrive already deserialised, with an end-of-block error flag.
// Notes: Write and link-receive ports are plain strobes; read and link-send ports use valid and ready; five level pins pass two flip-flops, I_ARB_WIN none.
`include "rbtl_defs.vh"
module redundant_block_transfer_link #(
    parameter SWITCH_CYCLES = `SWITCH_MS * `CLK_MHZ * 1000,
    parameter ARB_CYCLES = 1000
) (
    input wire I_CLK_SYS,
    input wire I_RST_N,
    input wire I_FAST_MODE,
    input wire I_PARTNER_ALIVE,
    input wire I_PROC_PROGRAM,
    input wire I_LOCAL_FAULT,
    input wire I_TAKEOVER_CMD,
    input wire I_ARB_WIN,
    input wire [7:0] I_NODE_ADDR,
    input wire I_BTW_START,
    input wire [6:0] I_BTW_LEN,
    input wire I_BTW_VALID,
    input wire [15:0] I_BTW_DATA,
    input wire I_BTW_LAST,
    input wire I_BTR_REQ,
    input wire I_BTR_READY,
    output wire O_BTR_VALID,
    output wire [15:0] O_BTR_DATA,
    output reg O_BTR_LAST,
    output reg O_LINK_VALID,
    input wire I_LINK_READY,
    output reg [15:0] O_LINK_DATA,
    output reg O_LINK_END,
    input wire I_LINK_RX_VALID,
    input wire [15:0] I_LINK_RX_DATA,
    input wire I_LINK_RX_END,
    input wire I_LINK_RX_ERR,
    input wire [7:0] I_LINK_RX_COUNT,
    output reg O_RELAY_CLOSE,
    output reg O_TAKEOVER_REQ,
    output reg O_IS_PRIMARY,
    output reg O_DATA_VALID,
    output reg [7:0] O_ACCESS_NODE,
    output reg [15:0] O_STATUS
);
    localparam ROLE_ARB = `ROLE_ARB;
    localparam ROLE_PRI = `ROLE_PRI;
    localparam ROLE_SEC = `ROLE_SEC;
    localparam ROLE_FAULT = `ROLE_FAULT;
    localparam RD_IDLE = 2'h0;
    localparam RD_HDR = 2'h1;
    localparam RD_DATA = 2'h2;
    // Pin inputs through two flip-flops; only stage two is read.
    reg [4:0] pin_a_q;
    reg [4:0] pin_b_q;
    wire fast = pin_b_q[0];
    wire partner = pin_b_q[1];
    wire prog = pin_b_q[2];
    wire fault = pin_b_q[3];
    wire takeover = pin_b_q[4];
    always @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            pin_a_q <= 5'h00;
            pin_b_q <= 5'h00;
        end else begin
            pin_a_q <= {I_TAKEOVER_CMD, I_LOCAL_FAULT, I_PROC_PROGRAM, I_PARTNER_ALIVE,
                I_FAST_MODE};
            pin_b_q <= pin_a_q;
        end
    end
    // Role machine and relay timing.
    reg [1:0] role_q;
    reg [31:0] tmr_q;
    reg sw_pend_q;
    reg started_q;
    always @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            role_q <= ROLE_ARB;
            tmr_q <= 32'h0;
            sw_pend_q <= 1'b0;
            O_RELAY_CLOSE <= 1'b0;
            O_TAKEOVER_REQ <= 1'b0;
        end else begin
            O_TAKEOVER_REQ <= 1'b0;
            case (role_q)
                ROLE_ARB: begin
                    O_RELAY_CLOSE <= 1'b0;
                    tmr_q <= tmr_q + 32'h1;
                    if (prog && partner) begin
                        role_q <= ROLE_SEC;
                    end else if (partner && !I_ARB_WIN) begin
                        role_q <= ROLE_SEC;
                    end else if (tmr_q >= ARB_CYCLES) begin
                        role_q <= ROLE_PRI;
                        O_RELAY_CLOSE <= 1'b1;
                    end
                end
                ROLE_PRI: begin
                    if (fault) begin
                        O_RELAY_CLOSE <= 1'b0;
                        O_TAKEOVER_REQ <= 1'b1;
                        role_q <= ROLE_FAULT;
                    end
                end
                ROLE_SEC: begin
                    O_RELAY_CLOSE <= 1'b0;
                    if (takeover && !sw_pend_q) begin
                        sw_pend_q <= 1'b1;
                        tmr_q <= 32'h0;
                    end else if (sw_pend_q) begin
                        tmr_q <= tmr_q + 32'h1;
                        // Close two counts short of the bound rather than exactly at it.
                        if (tmr_q >= SWITCH_CYCLES - 2) begin
                            O_RELAY_CLOSE <= 1'b1;
                            role_q <= ROLE_PRI;
                            sw_pend_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    O_RELAY_CLOSE <= 1'b0;
                end
            endcase
        end
    end
    wire is_pri = (role_q == ROLE_PRI);
    wire is_sec = (role_q == ROLE_SEC);
    // Primary write path: collect a block, forward it one at a time.
    reg [15:0] blk_q [0:63];
    reg [6:0] wcnt_q;
    reg [6:0] scnt_q;
    reg sending_q;
    reg err_pend_q;
    reg [7:0] seg_len_q;
    reg first_q;
    wire len_ok = (I_BTW_LEN == `LEN_AUTO);
    always @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            wcnt_q <= 7'h00;
            scnt_q <= 7'h00;
            sending_q <= 1'b0;
            err_pend_q <= 1'b0;
            seg_len_q <= `SEQ_ONE;
            first_q <= 1'b0;
            O_LINK_VALID <= 1'b0;
            O_LINK_DATA <= 16'h0000;
            O_LINK_END <= 1'b0;
        end else begin
            if (I_BTW_START) begin
                wcnt_q <= 7'h00;
                first_q <= 1'b1;
                err_pend_q <= !len_ok;
            end
            if (I_BTW_VALID && !sending_q && wcnt_q < `BLOCK_MAX_WORDS) begin
                if (is_sec && first_q) begin
                    seg_len_q <= I_BTW_DATA[7:0];
                end else begin
                    blk_q[wcnt_q[5:0]] <= I_BTW_DATA;
                    wcnt_q <= wcnt_q + 7'h01;
                end
                first_q <= 1'b0;
            end else if (I_BTW_VALID) begin
                err_pend_q <= 1'b1;
            end
            if (I_BTW_LAST && is_pri && !fault && !err_pend_q && wcnt_q != 7'h00) begin
                sending_q <= 1'b1;
                scnt_q <= 7'h00;
            end
            if (sending_q && (!O_LINK_VALID || I_LINK_READY)) begin
                if (fault || !is_pri) begin
                    sending_q <= 1'b0;
                    O_LINK_VALID <= 1'b0;
                    wcnt_q <= 7'h00;
                end else if (scnt_q < wcnt_q) begin
                    O_LINK_VALID <= 1'b1;
                    O_LINK_DATA <= blk_q[scnt_q[5:0]];
                    O_LINK_END <= (scnt_q == wcnt_q - 7'h01);
                    scnt_q <= scnt_q + 7'h01;
                end else begin
                    O_LINK_VALID <= 1'b0;
                    O_LINK_END <= 1'b0;
                    sending_q <= 1'b0;
                    wcnt_q <= 7'h00;
                end
            end
        end
    end
    // Secondary receive path: stage a block, commit only when clean.
    reg [15:0] rx_q [0:63];
    reg [6:0] rcnt_q;
    reg [6:0] rlen_q;
    reg rel_q;
    reg [7:0] got_q;
    reg [7:0] seq_q;
    reg [6:0] rptr_q;
    reg [1:0] rd_q;
    reg [15:0] rd_word;
    reg rd_push;
    wire rd_ready;
    wire blk_ok = I_LINK_RX_VALID && I_LINK_RX_END && !I_LINK_RX_ERR;
    always @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            rcnt_q <= 7'h00;
            rlen_q <= 7'h00;
            rel_q <= 1'b0;
            got_q <= `SEQ_ZERO;
            O_DATA_VALID <= 1'b0;
        end else begin
            if (I_LINK_RX_VALID && is_sec) begin
                if (rcnt_q < `BLOCK_MAX_WORDS) begin
                    rx_q[rcnt_q[5:0]] <= I_LINK_RX_DATA;
                end
                rcnt_q <= I_LINK_RX_END ? 7'h00 : rcnt_q + 7'h01;
                if (blk_ok) begin
                    rlen_q <= rcnt_q + 7'h01;
                    got_q <= got_q + 8'h01;
                    if (fast) begin
                        O_DATA_VALID <= 1'b1;
                        rel_q <= 1'b1;
                    end else if (got_q + 8'h01 == seg_len_q &&
                                 got_q + 8'h01 == I_LINK_RX_COUNT) begin
                        O_DATA_VALID <= 1'b1;
                        rel_q <= 1'b1;
                        got_q <= `SEQ_ZERO;
                    end
                end else if (I_LINK_RX_END) begin
                    got_q <= got_q;
                end
            end
            if (rd_q == RD_IDLE && I_BTR_REQ && rel_q && is_sec) begin
                rel_q <= 1'b0;
                O_DATA_VALID <= fast ? 1'b0 : O_DATA_VALID;
            end
        end
    end
    // Block read path feeding the two-entry buffer.
    reg [1:0] hcnt_q;
    reg data_rd_q;
    always @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            rd_q <= RD_IDLE;
            seq_q <= `SEQ_ZERO;
            rptr_q <= 7'h00;
            hcnt_q <= 2'h0;
            data_rd_q <= 1'b0;
            O_BTR_LAST <= 1'b0;
        end else begin
            case (rd_q)
                RD_IDLE: begin
                    O_BTR_LAST <= 1'b0;
                    if (I_BTR_REQ) begin
                        rd_q <= RD_HDR;
                        hcnt_q <= 2'h0;
                        rptr_q <= 7'h00;
                        data_rd_q <= is_sec && rel_q;
                        if (is_pri && (!partner || !started_q)) begin
                            seq_q <= `SEQ_ONE;
                        end else if (is_sec && rel_q) begin
                            seq_q <= seq_q + 8'h01;
                        end else if (is_sec) begin
                            seq_q <= `SEQ_ZERO;
                        end
                    end
                    if (!is_sec && !is_pri) begin
                        seq_q <= `SEQ_ZERO;
                    end
                end
                RD_HDR: begin
                    if (rd_ready) begin
                        hcnt_q <= hcnt_q + 2'h1;
                        if (hcnt_q == 2'h1) begin
                            rd_q <= data_rd_q ? RD_DATA : RD_IDLE;
                        end
                    end
                end
                RD_DATA: begin
                    if (rd_ready) begin
                        rptr_q <= rptr_q + 7'h01;
                        if (rptr_q + 7'h01 >= rlen_q) begin
                            rd_q <= RD_IDLE;
                        end
                    end
                end
                default: begin
                    rd_q <= RD_IDLE;
                end
            endcase
            if (is_pri && rd_q == RD_HDR && hcnt_q == 2'h1 && rd_ready) begin
                seq_q <= seq_q;
            end
        end
    end
    // Seed counter: primary reports block one until it has answered once with partner up.
    always @* begin
        rd_push = (rd_q == RD_HDR) || (rd_q == RD_DATA);
        if (rd_q == RD_HDR) begin
            rd_word = (hcnt_q == 2'h0) ? O_STATUS : {8'h00, seq_q};
        end else begin
            rd_word = rx_q[rptr_q[5:0]];
        end
    end
    always @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            O_STATUS <= 16'h0000;
            O_IS_PRIMARY <= 1'b0;
            O_ACCESS_NODE <= 8'h00;
        end else begin
            O_STATUS <= 16'h0000;
            O_STATUS[`ST_PRIMARY_BIT] <= is_pri;
            O_STATUS[`ST_VALID_BIT] <= O_DATA_VALID;
            O_STATUS[`ST_SWITCH_BIT] <= sw_pend_q;
            O_STATUS[`ST_FAST_BIT] <= fast;
            O_IS_PRIMARY <= is_pri;
            O_ACCESS_NODE <= I_NODE_ADDR + 8'h01;
        end
    end
    // Sole driver of the seed flag; it restarts whenever this side is not primary.
    always @(posedge I_CLK_SYS) begin
        if (!I_RST_N || !is_pri) begin
            started_q <= 1'b0;
        end else if (rd_q == RD_HDR && partner && hcnt_q == 2'h1 && rd_ready) begin
            started_q <= 1'b1;
        end
    end
    word_skid #(
        .W(16)
    ) u_rd_buf (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_valid(rd_push),
        .o_ready(rd_ready),
        .i_data(rd_word),
        .o_valid(O_BTR_VALID),
        .i_ready(I_BTR_READY),
        .o_data(O_BTR_DATA)
    );
endmodule // redundant_block_transfer_link

// ---- tb/rbtl_chk.sv ----
// Purpose: Port-level assertions for the redundant block transfer link.
// Assumes: One clock, synchronous active-low reset, short switch count.
// Notes: Level inputs pass a two-flop synchroniser, so fast-mode holds are five cycles and the fault hold four.
module rbtl_chk #(
    parameter SWITCH_CYCLES = 50
) (
    input wire I_CLK_SYS,
    input wire I_RST_N,
    input wire I_FAST_MODE,
    input wire I_LOCAL_FAULT,
    input wire I_TAKEOVER_CMD,
    input wire [7:0] I_NODE_ADDR,
    input wire I_BTR_READY,
    input wire O_BTR_VALID,
    input wire [15:0] O_BTR_DATA,
    input wire O_LINK_VALID,
    input wire I_LINK_READY,
    input wire [15:0] O_LINK_DATA,
    input wire O_LINK_END,
    input wire I_LINK_RX_VALID,
    input wire I_LINK_RX_END,
    input wire I_LINK_RX_ERR,
    input wire O_RELAY_CLOSE,
    input wire O_TAKEOVER_REQ,
    input wire O_IS_PRIMARY,
    input wire O_DATA_VALID,
    input wire [7:0] O_ACCESS_NODE,
    input wire [15:0] O_STATUS
);
    localparam int SW_MAX = SWITCH_CYCLES + 6;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    sequence s_fault_held; I_LOCAL_FAULT [*4]; endsequence
    sequence s_fast_on; I_FAST_MODE [*5]; endsequence
    sequence s_fast_off; !I_FAST_MODE [*5]; endsequence
    property p_node;
        $stable(I_NODE_ADDR) && $past(I_RST_N) && $past(I_RST_N, 2)
            |-> O_ACCESS_NODE == I_NODE_ADDR + 8'h01;
    endproperty
    property p_fast_on; s_fast_on |-> O_STATUS[11]; endproperty
    property p_fast_off; s_fast_off |-> !O_STATUS[11]; endproperty
    property p_fault; s_fault_held |-> !O_RELAY_CLOSE; endproperty
    property p_tko; O_IS_PRIMARY && $rose(I_LOCAL_FAULT) |-> ##[1:6] O_TAKEOVER_REQ; endproperty
    property p_pulse; O_TAKEOVER_REQ |=> !O_TAKEOVER_REQ; endproperty
    property p_arb; $rose(I_RST_N) |-> !O_RELAY_CLOSE [*8]; endproperty
    property p_switch;
        !O_IS_PRIMARY && !O_RELAY_CLOSE && $rose(I_TAKEOVER_CMD) |-> ##[1:SW_MAX] O_RELAY_CLOSE;
    endproperty
    property p_btr_hold;
        O_BTR_VALID && !I_BTR_READY |=> O_BTR_VALID && $stable(O_BTR_DATA);
    endproperty
    property p_link_hold;
        O_LINK_VALID && !I_LINK_READY && !I_LOCAL_FAULT
            |=> O_LINK_VALID && $stable(O_LINK_DATA) && $stable(O_LINK_END);
    endproperty
    property p_rx_err;
        I_LINK_RX_VALID && I_LINK_RX_END && I_LINK_RX_ERR && !O_DATA_VALID
            |=> !O_DATA_VALID [*3];
    endproperty
    a_node: assert property (p_node) else $error("access node not one above");
    a_fast_on: assert property (p_fast_on) else $error("fast bit low");
    a_fast_off: assert property (p_fast_off) else $error("fast bit high");
    a_fault: assert property (p_fault) else $error("relay closed on fault");
    a_tko: assert property (p_tko) else $error("no takeover request");
    a_pulse: assert property (p_pulse) else $error("takeover request too long");
    a_arb: assert property (p_arb) else $error("relay closed in arbitration");
    a_switch: assert property (p_switch) else $error("relay not closed in time");
    a_btr_hold: assert property (p_btr_hold) else $error("read word lost on stall");
    a_link_hold: assert property (p_link_hold) else $error("link word lost on stall");
    a_rx_err: assert property (p_rx_err) else $error("errored block raised valid");
endmodule // rbtl_chk
bind redundant_block_transfer_link rbtl_chk #(.SWITCH_CYCLES(SWITCH_CYCLES)) rbtl_chk_inst (
    .I_CLK_SYS, .I_RST_N, .I_FAST_MODE, .I_LOCAL_FAULT, .I_TAKEOVER_CMD, .I_NODE_ADDR,
    .I_BTR_READY, .O_BTR_VALID, .O_BTR_DATA, .O_LINK_VALID, .I_LINK_READY, .O_LINK_DATA,
    .O_LINK_END, .I_LINK_RX_VALID, .I_LINK_RX_END, .I_LINK_RX_ERR, .O_RELAY_CLOSE,
    .O_TAKEOVER_REQ, .O_IS_PRIMARY, .O_DATA_VALID, .O_ACCESS_NODE, .O_STATUS);

// ---- tb/rbtl_link_sink.sv ----
// Purpose: Far end of the outgoing serial link, collecting sent words.
// Assumes: Words are taken at the rising edge where valid and ready are high.
// Notes: Stalls every fifth cycle so the sender must hold its word.
module rbtl_link_sink (
    input wire logic i_clk,
    input wire logic i_valid,
    input wire logic [15:0] i_data,
    input wire logic i_end,
    output logic o_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] got_words[$];
    int n_end;
    int phase;
    initial begin
        o_ready = 1'b0;
        n_end = 0;
        phase = 0;
        forever begin
            @(negedge i_clk);
            phase++;
            o_ready = (phase % 5) != 0;
            if (i_valid && o_ready) begin
                got_words.push_back(i_data);
                if (i_end) n_end++;
            end
        end
    end
endmodule // rbtl_link_sink

// ---- tb/redundant_block_transfer_link_tb.sv ----
// Purpose: Self-checking bench for the redundant block transfer link.
// Assumes: Inputs change at the falling edge; short switch and arbitration counts.
// Notes: Handshakes seen at a falling edge complete at the next rising edge.
module redundant_block_transfer_link_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SWC = 50;
    logic clk, rst_n, fast, alive, prog, fault, tko, arb_win, btw_start, btw_valid, btw_last;
    logic btr_req, btr_ready, rx_valid, rx_end, rx_err;
    logic [6:0] btw_len;
    logic [7:0] node, rx_count;
    logic [15:0] btw_data, rx_data;
    wire btr_valid, btr_last, lnk_valid, lnk_ready, lnk_end, relay, tko_req, is_pri, dvalid;
    wire [15:0] btr_data, lnk_data, status;
    wire [7:0] acc_node;
    int n_mismatch, checks_done;
    logic [15:0] rd[$];
    redundant_block_transfer_link #(.SWITCH_CYCLES(SWC), .ARB_CYCLES(20))
        redundant_block_transfer_link_inst (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_FAST_MODE(fast), .I_PARTNER_ALIVE(alive),
        .I_PROC_PROGRAM(prog), .I_LOCAL_FAULT(fault), .I_TAKEOVER_CMD(tko), .I_ARB_WIN(arb_win),
        .I_NODE_ADDR(node), .I_BTW_START(btw_start), .I_BTW_LEN(btw_len),
        .I_BTW_VALID(btw_valid), .I_BTW_DATA(btw_data), .I_BTW_LAST(btw_last),
        .I_BTR_REQ(btr_req), .I_BTR_READY(btr_ready), .O_BTR_VALID(btr_valid),
        .O_BTR_DATA(btr_data), .O_BTR_LAST(btr_last), .O_LINK_VALID(lnk_valid),
        .I_LINK_READY(lnk_ready), .O_LINK_DATA(lnk_data), .O_LINK_END(lnk_end),
        .I_LINK_RX_VALID(rx_valid), .I_LINK_RX_DATA(rx_data), .I_LINK_RX_END(rx_end),
        .I_LINK_RX_ERR(rx_err), .I_LINK_RX_COUNT(rx_count), .O_RELAY_CLOSE(relay),
        .O_TAKEOVER_REQ(tko_req), .O_IS_PRIMARY(is_pri), .O_DATA_VALID(dvalid),
        .O_ACCESS_NODE(acc_node), .O_STATUS(status));
    rbtl_link_sink rbtl_link_sink_inst (.i_clk(clk), .i_valid(lnk_valid), .i_data(lnk_data),
        .i_end(lnk_end), .o_ready(lnk_ready));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic boot(input logic f, input logic a, input logic p);
        @(negedge clk);
        rst_n = 1'b0; fast = f; alive = a; prog = p; fault = 1'b0; tko = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (40) @(negedge clk);
    endtask
    // Length stays zero unless a refusal is wanted; the module sizes the block itself.
    task automatic block_write_transfer(input int n, input logic [6:0] len, input logic [15:0] base);
        @(negedge clk);
        btw_start = 1'b1; btw_len = len;
        @(negedge clk);
        btw_start = 1'b0;
        for (int i = 0; i < n; i++) begin
            btw_valid = 1'b1; btw_data = base + 16'(i); btw_last = (i == n - 1);
            @(negedge clk);
        end
        btw_valid = 1'b0; btw_last = 1'b0; btw_len = 7'h00;
    endtask
    task automatic lrx(input int n, input logic err, input logic [7:0] cnt, input logic [15:0] b);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rx_valid = 1'b1; rx_data = b + 16'(i); rx_end = (i == n - 1); rx_err = err;
            rx_count = cnt;
        end
        @(negedge clk);
        rx_valid = 1'b0; rx_end = 1'b0; rx_err = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    // A read ends once twelve cycles pass without a word.
    task automatic block_read_transfer();
        int idle;
        idle = 0;
        rd.delete();
        @(negedge clk);
        btr_req = 1'b1;
        @(negedge clk);
        btr_req = 1'b0;
        for (int t = 0; t < 300 && idle < 12; t++) begin
            btr_ready = (t % 4) != 3;
            if (btr_valid && btr_ready) begin
                rd.push_back(btr_data);
                idle = 0;
            end else idle++;
            @(negedge clk);
        end
    endtask
    task automatic wait_sent(input int k);
        for (int t = 0; t < 400 && rbtl_link_sink_inst.n_end < k; t++) @(negedge clk);
        if (rbtl_link_sink_inst.n_end < k) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        n_mismatch = 0; checks_done = 0; rst_n = 1'b0; fast = 1'b0; alive = 1'b0;
        prog = 1'b0; fault = 1'b0; tko = 1'b0; arb_win = 1'b1; node = 8'h10; btw_start = 1'b0;
        btw_len = 7'h00; btw_valid = 1'b0; btw_data = 16'h0000; btw_last = 1'b0;
        btr_req = 1'b0; btr_ready = 1'b1; rx_valid = 1'b0; rx_data = 16'h0000;
        rx_end = 1'b0; rx_err = 1'b0; rx_count = 8'h00;
        boot(1'b0, 1'b0, 1'b0);
        chk("primary", 16'h0001, {15'h0000, is_pri});
        chk("relay", 16'h0001, {15'h0000, relay});
        chk("node", 16'h0011, {8'h00, acc_node});
        block_read_transfer();
        chk("read words", 16'h0002, 16'(rd.size()));
        chk("first seq", 16'h0001, rd[1]);
        chk("read last", 16'h0000, {15'h0000, btr_last});
        block_write_transfer(64, 7'h00, 16'h1000);
        wait_sent(1);
        chk("sent words", 16'h0040, 16'(rbtl_link_sink_inst.got_words.size()));
        chk("sent last", 16'h103f, rbtl_link_sink_inst.got_words[63]);
        block_write_transfer(3, 7'h00, 16'h2000);
        wait_sent(2);
        chk("second last", 16'h2002, rbtl_link_sink_inst.got_words[66]);
        block_write_transfer(4, 7'h01, 16'h2100);
        repeat (40) @(negedge clk);
        chk("errored sent", 16'h0043, 16'(rbtl_link_sink_inst.got_words.size()));
        fault = 1'b1;
        repeat (8) @(negedge clk);
        chk("fault relay", 16'h0000, {15'h0000, relay});
        boot(1'b0, 1'b1, 1'b1);
        chk("backup", 16'h0000, {15'h0000, is_pri});
        block_write_transfer(1, 7'h00, 16'h0003);
        lrx(4, 1'b0, 8'h03, 16'h3000);
        chk("valid one", 16'h0000, {15'h0000, dvalid});
        lrx(4, 1'b1, 8'h03, 16'h3100);
        chk("valid err", 16'h0000, {15'h0000, dvalid});
        lrx(4, 1'b0, 8'h03, 16'h3100);
        lrx(4, 1'b0, 8'h03, 16'h3200);
        chk("valid all", 16'h0001, {15'h0000, dvalid});
        // The receive store holds one block, so a full segment is read as its last block.
        block_read_transfer();
        chk("seg words", 16'h0006, 16'(rd.size()));
        chk("seg status valid", 16'h0001, {15'h0000, rd[0][1]});
        chk("seg seq", 16'h0001, rd[1]);
        chk("seg data", 16'h3200, rd[2]);
        block_read_transfer();
        chk("empty words", 16'h0002, 16'(rd.size()));
        chk("empty seq", 16'h0000, rd[1]);
        boot(1'b1, 1'b1, 1'b1);
        for (int b = 1; b <= 3; b++) begin
            lrx(4, 1'b0, 8'h03, 16'h4000 + 16'((b - 1) * 256));
            chk("fast valid", 16'h0001, {15'h0000, dvalid});
            block_read_transfer();
            chk("block words", 16'h0006, 16'(rd.size()));
            chk("status valid", 16'h0001, {15'h0000, rd[0][1]});
            chk("seq", 16'(b), rd[1]);
            chk("data", 16'h4000 + 16'((b - 1) * 256), rd[2]);
        end
        chk("fast bit", 16'h0001, {15'h0000, status[11]});
        tko = 1'b1;
        for (int t = 0; t < SWC + 20 && !relay; t++) @(negedge clk);
        chk("switch relay", 16'h0001, {15'h0000, relay});
        repeat (3) @(negedge clk);
        chk("new primary", 16'h0001, {15'h0000, is_pri});
        print_verdict();
    end
endmodule // redundant_block_transfer_link_tb
